/* File: common/pssc_cfg.svh */
// Register offsets, field positions, reset values and timing counts for the power-state block.
`ifndef PSSC_CFG_SVH
`define PSSC_CFG_SVH
`define PSSC_CTRL_OFS        12'h000
`define PSSC_TEST_OFS        12'h004
`define PSSC_CTO_OFS         12'h008
`define PSSC_CNT_OFS         12'h00c
`define PSSC_CMASK_OFS       12'h010
`define PSSC_SMASK_OFS       12'h014
`define PSSC_STATUS_OFS      12'h018
`define PSSC_FAULT_OFS       12'h01c
`define PSSC_CTRL_POWER_DOWN_REQUEST_BIT  0
`define PSSC_TEST_INH_BIT    0
`define PSSC_TEST_DIGITAL_SUPPLY_BIT   1
`define PSSC_TEST_COMP_BIT   2
`define PSSC_CTO_RST         24'h000400
`define PSSC_MASK_RST        16'h0000
`define PSSC_CLK_HZ          200000000
`define PSSC_TICK_HZ         4000
`define PSSC_TICK_DIV        (`PSSC_CLK_HZ / `PSSC_TICK_HZ)
`define PSSC_SUPPLY_DLY_US   100
`define PSSC_SUPPLY_DLY_CYC  ((`PSSC_SUPPLY_DLY_US * 200) - 1)
`define PSSC_TONE_NS         1000
`define PSSC_TONE_CYC        (`PSSC_TONE_NS / 5)
`define PSSC_CNT_W           32
`define PSSC_CNT_VIS         24
`endif

/* File: common/pssc_pkg.sv */
// Types shared by the power-state and shutdown control block.
`default_nettype none
package pssc_pkg;
   typedef enum logic [1:0] {
      PSSC_SLEEP  = 2'b00,
      PSSC_IDLE   = 2'b01,
      PSSC_ACTIVE = 2'b11
   } pssc_state_t;
   typedef struct packed {
      logic io_supply_low;
      logic regulated_supply_low;
      logic digital_supply_low;
      logic always_on_5v_supply_low;
      logic pass_transistor_base_drive;
      logic supplies_lowered;
   } pssc_supply_t;
   typedef struct packed {
      logic thermal_trip_analog;
      logic thermal_trip_digital;
   } pssc_thermal_t;
endpackage
`default_nettype wire

/* File: design/pssc_top.sv */
// Power-state and shutdown controller with AXI4-Lite register access.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`default_nettype none
`include "pssc_cfg.svh"
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
module pssc_top
   import pssc_pkg::*;
#(
   parameter int unsigned TICK_DIV   = `PSSC_TICK_DIV,
   parameter int unsigned SUPPLY_DLY = `PSSC_SUPPLY_DLY_CYC,
   parameter int unsigned TONE_LEN   = `PSSC_TONE_CYC
) (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // AXI4-Lite slave
   input  wire logic [11:0]   s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output var  logic          s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output var  logic          s_axi_wready,
   output var  logic [1:0]    s_axi_bresp,
   output var  logic          s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [11:0]   s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output var  logic          s_axi_arready,
   output var  logic [31:0]   s_axi_rdata,
   output var  logic [1:0]    s_axi_rresp,
   output var  logic          s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Wake and link
   input  wire logic          wake_pin,
   input  wire logic          lower_link_wake_tone,
   input  wire logic          valid_frame,
   input  wire logic          comm_busy,
   input  wire logic [15:0]   comm_error,
   output var  logic          upper_link_pins_tone,
   // Supplies, thermal and comparators
   input  wire pssc_supply_t  supply,
   input  wire pssc_thermal_t thermal_trip,
   input  wire logic [15:0]   comp_ov_raw,
   // Status
   output var  logic [1:0]    power_state,
   output var  logic          comm_fault
);
   localparam int unsigned CW = `PSSC_CNT_W;
   localparam int unsigned HW = CW - `PSSC_CNT_VIS;

   pssc_state_t          state_reg;
   logic                 power_down_request;
   logic                 timeout_reset_inhibit;
   logic                 digital_supply_test;
   logic                 comp_enable;
   logic                 digital_supply_latch_reg;
   logic [23:0]          comm_timeout_period;
   logic [CW-1:0]        comm_timeout_count_reg;
   logic [15:0]          comm_fault_mask_reg;
   logic [15:0]          system_fault_mask_reg;
   logic [15:0]          ov_fault_reg;
   logic [1:0]           thermal_flag_reg;
   logic [15:0]          tick_cnt_reg;
   logic                 tick;
   logic [31:0]          io_dly_reg;
   logic [31:0]          vp_dly_reg;
   logic                 io_loss;
   logic                 vp_loss;
   logic                 timeout;
   logic                 sleep_cond;
   logic                 wake_event;
   logic                 comp_en_d_reg;
   logic [15:0]          tone_cnt_reg;
   logic                 aw_hold_reg;
   logic                 w_hold_reg;
   logic [11:0]          awaddr_reg;
   logic [31:0]          wdata_reg;
   logic                 do_write;
   logic                 wake_reset;

   // -----------------------------------------------------------------------------
   // AXI4-Lite write path
   // -----------------------------------------------------------------------------
   // Address and data are held separately so either may arrive first.
   assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg   <= 1'b0;
         w_hold_reg    <= 1'b0;
         awaddr_reg    <= 12'h000;
         wdata_reg     <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else begin
         s_axi_awready <= !aw_hold_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_hold_reg && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awaddr_reg)
               `PSSC_CTRL_OFS, `PSSC_TEST_OFS, `PSSC_CTO_OFS, `PSSC_CNT_OFS,
               `PSSC_CMASK_OFS, `PSSC_SMASK_OFS, `PSSC_FAULT_OFS: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------------------
   // A wake clears every software setting back to its default value.
   assign wake_reset = (state_reg == PSSC_SLEEP) && wake_event;

   always_ff @(posedge aclk) begin
      if (!aresetn || wake_reset) begin
         power_down_request    <= 1'b0;
         timeout_reset_inhibit <= 1'b0;
         digital_supply_test   <= 1'b0;
         comp_enable           <= 1'b1;
         comm_timeout_period   <= `PSSC_CTO_RST;
         comm_fault_mask_reg   <= `PSSC_MASK_RST;
         system_fault_mask_reg <= `PSSC_MASK_RST;
      end else if (state_reg == PSSC_SLEEP) begin
         power_down_request <= 1'b0;
      end else if (do_write) begin
         case (awaddr_reg)
            `PSSC_CTRL_OFS: power_down_request <= wdata_reg[`PSSC_CTRL_POWER_DOWN_REQUEST_BIT];
            `PSSC_TEST_OFS: begin
               timeout_reset_inhibit <= wdata_reg[`PSSC_TEST_INH_BIT];
               digital_supply_test   <= wdata_reg[`PSSC_TEST_DIGITAL_SUPPLY_BIT];
               comp_enable           <= wdata_reg[`PSSC_TEST_COMP_BIT];
            end
            `PSSC_CTO_OFS:   comm_timeout_period   <= wdata_reg[23:0];
            `PSSC_CMASK_OFS: comm_fault_mask_reg   <= wdata_reg[15:0];
            `PSSC_SMASK_OFS: system_fault_mask_reg <= wdata_reg[15:0];
            default: ;
         endcase
      end
   end

   // Latched digital-supply test survives a clear of its bit until sleep.
   always_ff @(posedge aclk) begin
      if (!aresetn || state_reg == PSSC_SLEEP) begin
         digital_supply_latch_reg <= 1'b0;
      end else if (digital_supply_test) begin
         digital_supply_latch_reg <= 1'b1;
      end
   end

   // -----------------------------------------------------------------------------
   // Comparator overvoltage faults
   // -----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || wake_reset) begin
         comp_en_d_reg <= 1'b1;
         ov_fault_reg  <= 16'h0000;
      end else begin
         comp_en_d_reg <= comp_enable;
         if (comp_enable && !comp_en_d_reg) begin
            ov_fault_reg <= 16'hffff;
         end else begin
            // A fresh fault beats a software clear in the same cycle.
            ov_fault_reg <= (comp_enable ? comp_ov_raw : 16'h0000) |
               (ov_fault_reg & ~((do_write && awaddr_reg == `PSSC_FAULT_OFS) ?
               wdata_reg[15:0] : 16'h0000));
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Timeout counter
   // -----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         tick_cnt_reg <= 16'h0000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
   end
   assign tick    = (tick_cnt_reg == 16'(TICK_DIV - 1));
   assign timeout = (comm_timeout_count_reg[CW-1:HW] >= comm_timeout_period);

   always_ff @(posedge aclk) begin
      if (!aresetn || state_reg == PSSC_SLEEP) begin
         comm_timeout_count_reg <= '0;
      end else if (do_write && awaddr_reg == `PSSC_CNT_OFS) begin
         comm_timeout_count_reg <= {wdata_reg[23:0], {HW{1'b1}}};
      end else if (valid_frame && !timeout_reset_inhibit) begin
         comm_timeout_count_reg <= '0;
      end else if (tick && !timeout) begin
         comm_timeout_count_reg <= comm_timeout_count_reg + 1'b1;
      end
   end

   // -----------------------------------------------------------------------------
   // Supply-loss delays
   // -----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || !supply.io_supply_low) begin
         io_dly_reg <= 32'h0000_0000;
      end else if (!io_loss) begin
         io_dly_reg <= io_dly_reg + 32'h0000_0001;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || !(supply.regulated_supply_low && supply.pass_transistor_base_drive)) begin
         vp_dly_reg <= 32'h0000_0000;
      end else if (!vp_loss) begin
         vp_dly_reg <= vp_dly_reg + 32'h0000_0001;
      end
   end
   assign io_loss = (io_dly_reg > SUPPLY_DLY);
   assign vp_loss = (vp_dly_reg > SUPPLY_DLY);

   // -----------------------------------------------------------------------------
   // Power-state machine
   // -----------------------------------------------------------------------------
   assign sleep_cond = power_down_request || timeout || io_loss || vp_loss ||
      supply.supplies_lowered || supply.always_on_5v_supply_low ||
      (digital_supply_latch_reg && supply.digital_supply_low) ||
      (|thermal_trip);
   assign wake_event = wake_pin || lower_link_wake_tone;

   // A high wake pin makes the sleep entry bounce straight back to idle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= PSSC_IDLE;
      end else begin
         case (state_reg)
            PSSC_SLEEP:  if (wake_event) state_reg <= PSSC_IDLE;
            PSSC_IDLE:   if (sleep_cond) state_reg <= PSSC_SLEEP;
                         else if (comm_busy) state_reg <= PSSC_ACTIVE;
            PSSC_ACTIVE: if (sleep_cond) state_reg <= PSSC_SLEEP;
                         else if (!comm_busy) state_reg <= PSSC_IDLE;
            default:     state_reg <= PSSC_SLEEP;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thermal_flag_reg <= 2'b00;
      end else if (wake_reset) begin
         thermal_flag_reg <= 2'b00;
      end else begin
         thermal_flag_reg <= thermal_flag_reg | thermal_trip;
      end
   end

   // -----------------------------------------------------------------------------
   // Wake tone and status outputs
   // -----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tone_cnt_reg         <= 16'h0000;
         upper_link_pins_tone <= 1'b0;
         power_state          <= 2'b01;
         comm_fault           <= 1'b0;
      end else begin
         power_state <= state_reg;
         if (power_state != state_reg) begin
            tone_cnt_reg <= 16'(TONE_LEN);
         end else if (tone_cnt_reg != 16'h0000) begin
            tone_cnt_reg <= tone_cnt_reg - 16'h0001;
         end
         upper_link_pins_tone <= (tone_cnt_reg != 16'h0000) && (state_reg != PSSC_SLEEP);
         comm_fault <= |(comm_error & comm_fault_mask_reg & system_fault_mask_reg);
      end
   end

   // -----------------------------------------------------------------------------
   // AXI4-Lite read path
   // -----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'b00;
            case (s_axi_araddr)
               `PSSC_CTRL_OFS:   s_axi_rdata <= {31'h0, power_down_request};
               `PSSC_TEST_OFS:   s_axi_rdata <= {29'h0, comp_enable, digital_supply_test,
                                                 timeout_reset_inhibit};
               `PSSC_CTO_OFS:    s_axi_rdata <= {8'h00, comm_timeout_period};
               `PSSC_CNT_OFS:    s_axi_rdata <= {8'h00, comm_timeout_count_reg[CW-1:HW]};
               `PSSC_CMASK_OFS:  s_axi_rdata <= {16'h0000, comm_fault_mask_reg};
               `PSSC_SMASK_OFS:  s_axi_rdata <= {16'h0000, system_fault_mask_reg};
               `PSSC_STATUS_OFS: s_axi_rdata <= {27'h0, digital_supply_latch_reg, thermal_flag_reg,
                                                 state_reg};
               `PSSC_FAULT_OFS:  s_axi_rdata <= {16'h0000, ov_fault_reg};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------------------
   sequence sleep_entry_s;
      state_reg != PSSC_SLEEP && sleep_cond;
   endsequence

   sleep_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sleep_entry_s |=> state_reg == PSSC_SLEEP) else $error("sleep not entered");
   sleep_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == PSSC_SLEEP && !wake_event |=> state_reg == PSSC_SLEEP)
      else $error("left sleep without wake");
   wake_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == PSSC_SLEEP && wake_event |=> state_reg == PSSC_IDLE)
      else $error("wake did not reach idle");
   bounce_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sleep_entry_s ##0 wake_pin ##1 wake_pin |=> state_reg == PSSC_IDLE)
      else $error("no immediate rewake");
   cnt_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && awaddr_reg == `PSSC_CNT_OFS && state_reg != PSSC_SLEEP
      |=> comm_timeout_count_reg[HW-1:0] == {HW{1'b1}})
      else $error("hidden counter bits not forced");
   inhibit_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      timeout_reset_inhibit && valid_frame && !do_write && state_reg != PSSC_SLEEP
      && !wake_reset |=> comm_timeout_count_reg >= $past(comm_timeout_count_reg))
      else $error("inhibited counter restarted");
   tone_send_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == PSSC_SLEEP ##1 state_reg == PSSC_IDLE |=> ##1 upper_link_pins_tone)
      else $error("wake tone missing");
   ov_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
      comp_enable && !comp_en_d_reg |=> ov_fault_reg == 16'hffff)
      else $error("ov faults not raised");
   digital_supply_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
      digital_supply_latch_reg && state_reg != PSSC_SLEEP |=> digital_supply_latch_reg || state_reg == PSSC_SLEEP)
      else $error("supply test latch lost");
endmodule
`default_nettype wire

/* File: tb/pssc_host_model.sv */
// Host-side partner: wake pin, wake tone from below and periodic valid frames.
`default_nettype none
module pssc_host_model #(
   parameter int GAP = 400
) (
   // Clock
   input  wire logic aclk,
   // Bench commands
   input  wire logic wake_req,
   input  wire logic tone_req,
   input  wire logic frames_on,
   // Toward the device
   output var  logic wake_pin,
   output var  logic wake_tone,
   output var  logic valid_frame
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial begin
      wake_pin = 1'b0;
      wake_tone = 1'b0;
      valid_frame = 1'b0;
   end
   // The pin is only high while a wake is wanted, so sleep can be held.
   always @(posedge aclk) begin
      wake_pin <= wake_req;
      wake_tone <= tone_req;
      cnt <= (cnt == GAP) ? 0 : cnt + 1;
      valid_frame <= frames_on && (cnt == GAP);
   end
endmodule
`default_nettype wire

/* File: tb/power_state_shutdown_control_tb_top.sv */
// Testbench for the power-state and shutdown controller.
`default_nettype none
`include "pssc_cfg.svh"
module power_state_shutdown_control_tb_top
   import pssc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid, wpin, wtone, vf, tone, cfault;
   logic [1:0] bresp, rresp, rr, rb, st;
   logic wake_req = 0, tone_req = 0, frames_on = 0, busy = 0, tone_seen = 0, sleep_seen = 0;
   logic [15:0] cerr = 0, ov = 0;
   pssc_supply_t sup = '0;
   pssc_thermal_t th = '0;
   pssc_supply_t tbl[4] = '{6'b100000, 6'b010010, 6'b000001, 6'b000100};
   int err_count = 0, num_checks = 0, cyc = 0;
   pssc_top #(.TICK_DIV(4), .SUPPLY_DLY(3), .TONE_LEN(4)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .wake_pin(wpin), .lower_link_wake_tone(wtone), .valid_frame(vf), .comm_busy(busy),
      .comm_error(cerr), .upper_link_pins_tone(tone), .supply(sup), .thermal_trip(th),
      .comp_ov_raw(ov), .power_state(st), .comm_fault(cfault));
   pssc_host_model host (.aclk(aclk), .wake_req(wake_req), .tone_req(tone_req),
      .frames_on(frames_on), .wake_pin(wpin), .wake_tone(wtone), .valid_frame(vf));
   // -------------------------------------------------------------------------
   // Clock, monitors and hang guard
   // -------------------------------------------------------------------------
   initial forever #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (tone === 1'b1) tone_seen <= 1'b1;
      if (st === PSSC_SLEEP) sleep_seen <= 1'b1;
      if (cyc == 30000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // -------------------------------------------------------------------------
   // Bus tasks: valid and payload hold until taken, ready holds until answer
   // -------------------------------------------------------------------------
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      logic ad, wd, dn;
      ad = 0;
      wd = 0;
      dn = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!dn) begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) awvalid <= 0;
         if (awready === 1'b1) ad = 1;
         if (!wd && wready === 1'b1) wvalid <= 0;
         if (wready === 1'b1) wd = 1;
         dn = (bvalid === 1'b1);
      end
      rb = bresp;
      bready <= 0;
   endtask
   task automatic axr(input logic [11:0] a);
      logic ad, dn;
      ad = 0;
      dn = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      while (!dn) begin
         @(posedge aclk);
         if (!ad && arready === 1'b1) arvalid <= 0;
         if (arready === 1'b1) ad = 1;
         dn = (rvalid === 1'b1);
      end
      rd = rdata;
      rr = rresp;
      rready <= 0;
   endtask
   task automatic wait_st(input string n, input logic [1:0] e, input int m);
      int i;
      i = 0;
      while (st !== e && i < m) begin
         @(posedge aclk);
         i++;
      end
      chk(n, {30'h0, e}, {30'h0, st});
   endtask
   // A wake by pin or by tone from below; the request is dropped once awake.
   task automatic wake(input logic pin);
      if (pin) wake_req <= 1;
      else tone_req <= 1;
      wait_st("wake", PSSC_IDLE, 100);
      wake_req <= 0;
      tone_req <= 0;
      repeat (4) @(posedge aclk);
   endtask
   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      chk("state", {30'h0, PSSC_IDLE}, {30'h0, st});
      axr(`PSSC_CTO_OFS);
      chk("period", 32'h400, rd);
      axr(12'h020);
      chk("unmapped", 32'h0, rd);
      chk("resp", 32'h2, {30'h0, rr});
      axw(12'h020, 32'h0);
      chk("bresp", 32'h2, {30'h0, rb});
      busy <= 1;
      wait_st("active", PSSC_ACTIVE, 20);
      busy <= 0;
      wait_st("idle", PSSC_IDLE, 20);
      cerr <= 16'h0001;
      axw(`PSSC_CMASK_OFS, 32'h1);
      chk("bresp", 32'h0, {30'h0, rb});
      repeat (3) @(posedge aclk);
      chk("fault", 32'h0, {31'h0, cfault});
      axw(`PSSC_SMASK_OFS, 32'h1);
      repeat (3) @(posedge aclk);
      chk("fault", 32'h1, {31'h0, cfault});
      cerr <= 16'h0;
      ov <= 16'h0001;
      axw(`PSSC_TEST_OFS, 32'h0);
      axw(`PSSC_TEST_OFS, 32'h4);
      ov <= 16'h0;
      axr(`PSSC_FAULT_OFS);
      chk("ov", 32'hffff, rd);
      axw(`PSSC_FAULT_OFS, 32'hffff);
      axr(`PSSC_FAULT_OFS);
      chk("ov", 32'h0, rd);
      // Frames run while inhibited, so any restart would show in the count.
      axw(`PSSC_TEST_OFS, 32'h5);
      frames_on <= 1;
      axw(`PSSC_CNT_OFS, 32'h10);
      repeat (10) @(posedge aclk);
      axr(`PSSC_CNT_OFS);
      chk("count", 32'h11, rd & 32'hffffff);
      repeat (1030) @(posedge aclk);
      axr(`PSSC_CNT_OFS);
      chk("count", 32'h12, rd & 32'hffffff);
      tone_seen <= 0;
      axw(`PSSC_CTO_OFS, 32'h13);
      wait_st("expiry", PSSC_SLEEP, 1200);
      repeat (8) @(posedge aclk);
      wake(1);
      chk("tone", 32'h1, {31'h0, tone_seen});
      axr(`PSSC_TEST_OFS);
      chk("test", 32'h4, rd);
      axw(`PSSC_CTO_OFS, 32'h1);
      repeat (3000) @(posedge aclk);
      chk("frames", {30'h0, PSSC_IDLE}, {30'h0, st});
      frames_on <= 0;
      wait_st("timeout", PSSC_SLEEP, 1300);
      wake(0);
      axw(`PSSC_CTRL_OFS, 32'h1);
      wait_st("power_down_request", PSSC_SLEEP, 50);
      axw(`PSSC_CTRL_OFS, 32'h0);
      repeat (20) @(posedge aclk);
      chk("held", {30'h0, PSSC_SLEEP}, {30'h0, st});
      wake(0);
      wake_req <= 1;
      repeat (4) @(posedge aclk);
      sleep_seen <= 0;
      axw(`PSSC_CTRL_OFS, 32'h1);
      repeat (100) @(posedge aclk);
      chk("cycled", 32'h1, {31'h0, sleep_seen});
      chk("rewoke", {30'h0, PSSC_IDLE}, {30'h0, st});
      wake_req <= 0;
      repeat (4) @(posedge aclk);
      for (int i = 0; i < 2; i++) begin
         th <= 2'(1 << i);
         wait_st("thermal", PSSC_SLEEP, 50);
         axr(`PSSC_STATUS_OFS);
         chk("flag", 32'(1 << i), (rd >> 2) & 32'h3);
         th <= '0;
         wake(0);
      end
      sup.io_supply_low <= 1;
      @(posedge aclk);
      sup <= 6'b011000;
      repeat (10) @(posedge aclk);
      chk("glitch", {30'h0, PSSC_IDLE}, {30'h0, st});
      for (int i = 0; i < 4; i++) begin
         sup <= tbl[i];
         wait_st("supply", PSSC_SLEEP, 30);
         sup <= '0;
         wake(0);
      end
      axw(`PSSC_TEST_OFS, 32'h6);
      axw(`PSSC_TEST_OFS, 32'h4);
      axr(`PSSC_STATUS_OFS);
      chk("latch", 32'h1, (rd >> 4) & 32'h1);
      sup.digital_supply_low <= 1;
      wait_st("dig", PSSC_SLEEP, 30);
      sup <= '0;
      wake(0);
      axr(`PSSC_STATUS_OFS);
      chk("latch", 32'h0, (rd >> 4) & 32'h1);
      end_sim();
   end
endmodule
`default_nettype wire
